/* File: rx_pll_config_lock_loss.sv */
// Behaviour
// - with auto-mute set the receiver audio output is held low during loss of lock, and with it clear (reset) no muting occurs.
// - loss of lock for auto-mute counts only when both the decoder and the recovered-clock loop report it.
// - with clock mode 0 (reset) the recovered clock stops when the recovered-clock loop alone reports loss of lock, with mode 1 it keeps running.
// - the three configuration registers at 0x0f to 0x11 hold the 4-bit pre-divider, 6-bit integer and 14-bit fraction.
// - the third configuration register holds fraction bits 7 down to 0.
`timescale 1ns/1ps
module rx_pll_config_lock_loss (
  // clock and reset
  input  wire logic                               core_clk_i,
  input  wire logic                               rst_i,
  // avalon-mm slave
  input  wire logic [7:0]                         avs_address_i,
  input  wire logic                               avs_read_i,
  input  wire logic                               avs_write_i,
  input  wire logic [31:0]                        avs_writedata_i,
  input  wire logic [3:0]                         avs_byteenable_i,
  output logic      [31:0]                        avs_readdata_o,
  output logic                                    avs_waitrequest_o,
  // lock indications from outside
  input  wire logic                               decoder_unlock_i,
  input  wire logic                               loop_unlock_i,
  // receiver audio path
  input  wire logic                               rx_audio_data_i,
  output logic                                    rx_audio_data_o,
  // recovered clock path
  input  wire logic                               rec_clk_tick_i,
  output logic                                    rec_clk_o,
  // reference multiplier loop settings
  output logic      [rx_clk_pkg::pdiv_w-1:0]      pre_div_o,
  output logic      [rx_clk_pkg::int_mult_w-1:0]  int_mult_o,
  output logic      [rx_clk_pkg::frac_mult_w-1:0] frac_mult_o
);
  import rx_clk_pkg::*;

  typedef struct packed {
    logic                   automute;
    logic                   clk_mode;
    logic [pdiv_w-1:0]      pdiv;
    logic [int_mult_w-1:0]  jmul;
    logic [frac_mult_w-1:0] dmul;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   audio;
    logic                   rclk;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic       lock_loss;
  logic       mute_on;
  logic       clk_stop;
  logic       req;
  logic [7:0] idx;
  logic [7:0] cfg1_val;
  logic [7:0] cfg2_val;

  lock_sync_if lk ();

  assign lk.decoder_unlock_raw = decoder_unlock_i;
  assign lk.loop_unlock_raw    = loop_unlock_i;

  lock_sync u_lock_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .lk         (lk.filter)
  );

  // ----------------------------------------------------------------
  // lock-loss decisions
  // ----------------------------------------------------------------
  assign lock_loss = lk.decoder_unlock & lk.loop_unlock;
  assign mute_on   = s.automute & lock_loss;
  assign clk_stop  = ~s.clk_mode & lk.loop_unlock;

  // ----------------------------------------------------------------
  // register packing
  // ----------------------------------------------------------------
  function automatic logic [7:0] word_index(input logic [7:0] a);
    word_index = {2'h0, a[7:2]};
  endfunction : word_index

  assign idx      = word_index(avs_address_i);
  assign req      = avs_read_i | avs_write_i;
  assign cfg1_val = {s.pdiv, s.jmul[5:2]};
  assign cfg2_val = {s.jmul[1:0], s.dmul[13:8]};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.ack   = req & ~s.ack;
    next_s.audio = mute_on ? 1'b0 : rx_audio_data_i;
    next_s.rclk  = clk_stop ? 1'b0 : rec_clk_tick_i;
    if (avs_read_i & ~s.ack) begin
      case (idx)
        lock_ctrl_idx:     next_s.rdata = {30'h0, s.clk_mode, s.automute};
        ref_mult_cfg1_idx: next_s.rdata = {24'h0, cfg1_val};
        ref_mult_cfg2_idx: next_s.rdata = {24'h0, cfg2_val};
        ref_mult_cfg3_idx: next_s.rdata = {24'h0, s.dmul[7:0]};
        lock_status_idx: begin
          next_s.rdata = {27'h0, clk_stop, mute_on, lock_loss,
                          lk.loop_unlock, lk.decoder_unlock};
        end
        default:           next_s.rdata = 32'h0;
      endcase
    end
    if (avs_write_i & s.ack & avs_byteenable_i[0]) begin
      case (idx)
        lock_ctrl_idx: begin
          next_s.automute = avs_writedata_i[automute_bit];
          next_s.clk_mode = avs_writedata_i[clk_mode_bit];
        end
        ref_mult_cfg1_idx: begin
          next_s.pdiv       = avs_writedata_i[cfg1_pdiv_lsb +: pdiv_w];
          next_s.jmul[5:2]  = avs_writedata_i[cfg1_jhi_lsb +: 4];
        end
        ref_mult_cfg2_idx: begin
          next_s.jmul[1:0]  = avs_writedata_i[cfg2_jlo_lsb +: 2];
          next_s.dmul[13:8] = avs_writedata_i[cfg2_dhi_lsb +: 6];
        end
        ref_mult_cfg3_idx: begin
          next_s.dmul[7:0]  = avs_writedata_i[7:0];
        end
        default: begin
          next_s.rdata = s.rdata;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.automute <= lock_ctrl_rst[automute_bit];
      s.clk_mode <= lock_ctrl_rst[clk_mode_bit];
      s.pdiv     <= ref_mult_cfg1_rst[cfg1_pdiv_lsb +: pdiv_w];
      s.jmul     <= {ref_mult_cfg1_rst[3:0], ref_mult_cfg2_rst[7:6]};
      s.dmul     <= {ref_mult_cfg2_rst[5:0], ref_mult_cfg3_rst};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest_o = req & ~s.ack;
  assign avs_readdata_o    = s.rdata;
  assign rx_audio_data_o   = s.audio;
  assign rec_clk_o         = s.rclk;
  assign pre_div_o         = s.pdiv;
  assign int_mult_o        = s.jmul;
  assign frac_mult_o       = s.dmul;
endmodule : rx_pll_config_lock_loss

/* File: rx_clk_pkg.sv */
package rx_clk_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] lock_ctrl_idx     = 8'h0e;
  localparam logic [7:0] ref_mult_cfg1_idx = 8'h0f;
  localparam logic [7:0] ref_mult_cfg2_idx = 8'h10;
  localparam logic [7:0] ref_mult_cfg3_idx = 8'h11;
  localparam logic [7:0] lock_status_idx   = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int automute_bit   = 0;
  localparam int clk_mode_bit   = 1;
  localparam int cfg1_pdiv_lsb  = 4;
  localparam int cfg1_jhi_lsb   = 0;
  localparam int cfg2_jlo_lsb   = 6;
  localparam int cfg2_dhi_lsb   = 0;
  localparam int pdiv_w         = 4;
  localparam int int_mult_w     = 6;
  localparam int frac_mult_w    = 14;
  localparam int sync_stages    = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] lock_ctrl_rst     = 8'h00;
  localparam logic [7:0] ref_mult_cfg1_rst = 8'h00;
  localparam logic [7:0] ref_mult_cfg2_rst = 8'h00;
  localparam logic [7:0] ref_mult_cfg3_rst = 8'h00;
endpackage : rx_clk_pkg

/* File: lock_sync_if.sv */
`timescale 1ns/1ps
interface lock_sync_if;
  logic decoder_unlock_raw;
  logic loop_unlock_raw;
  logic decoder_unlock;
  logic loop_unlock;

  modport filter (
    input  decoder_unlock_raw,
    input  loop_unlock_raw,
    output decoder_unlock,
    output loop_unlock
  );
  modport user (
    output decoder_unlock_raw,
    output loop_unlock_raw,
    input  decoder_unlock,
    input  loop_unlock
  );
endinterface : lock_sync_if

/* File: lock_sync.sv */
`timescale 1ns/1ps
module lock_sync (
  // clock and reset
  input  wire logic    core_clk_i,
  input  wire logic    rst_i,
  // lock flags
  lock_sync_if.filter  lk
);
  import rx_clk_pkg::*;

  typedef struct packed {
    logic [sync_stages-1:0] dec_sh;
    logic [sync_stages-1:0] loop_sh;
    logic                   dec;
    logic                   loop;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // ----------------------------------------------------------------
  // three-stage capture, change taken when stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.dec_sh  = {s.dec_sh[sync_stages-2:0], lk.decoder_unlock_raw};
    next_s.loop_sh = {s.loop_sh[sync_stages-2:0], lk.loop_unlock_raw};
    if (s.dec_sh[1] == s.dec_sh[2]) begin
      next_s.dec = s.dec_sh[2];
    end
    if (s.loop_sh[1] == s.loop_sh[2]) begin
      next_s.loop = s.loop_sh[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lk.decoder_unlock = s.dec;
  assign lk.loop_unlock    = s.loop;
endmodule : lock_sync

/* File: rx_clk_checker.sv */
`timescale 1ns/1ps
module rx_clk_checker (
  // clock, reset, bus
  input wire logic                                core_clk_i,
  input wire logic                                rst_i,
  input wire logic [7:0]                          avs_address_i,
  input wire logic                                avs_write_i,
  input wire logic [31:0]                         avs_writedata_i,
  input wire logic [3:0]                          avs_byteenable_i,
  input wire logic                                avs_waitrequest_o,
  // lock and data paths
  input wire logic                                decoder_unlock_i,
  input wire logic                                loop_unlock_i,
  input wire logic                                rx_audio_data_i,
  input wire logic                                rx_audio_data_o,
  input wire logic                                rec_clk_tick_i,
  input wire logic                                rec_clk_o,
  // loop settings
  input wire logic [rx_clk_pkg::pdiv_w-1:0]       pre_div_o,
  input wire logic [rx_clk_pkg::int_mult_w-1:0]   int_mult_o,
  input wire logic [rx_clk_pkg::frac_mult_w-1:0]  frac_mult_o
);
  import rx_clk_pkg::*;

  logic            am;
  logic            cm;
  wire logic       acc = avs_write_i && !avs_waitrequest_o
                         && avs_byteenable_i[0];
  wire logic [5:0] ix  = avs_address_i[7:2];
  wire logic [7:0] wd  = avs_writedata_i[7:0];
  // shadow of the lock control bits
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      am <= 1'b0;
      cm <= 1'b0;
    end else if (acc && ix == lock_ctrl_idx[5:0]) begin
      am <= wd[automute_bit];
      cm <= wd[clk_mode_bit];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  mute_on_loss_a: assert property (
    (am && decoder_unlock_i && loop_unlock_i)[*7] |-> !rx_audio_data_o)
    else $error("audio not forced low");
  mute_off_a: assert property (
    !am |=> rx_audio_data_o == $past(rx_audio_data_i))
    else $error("audio muted while disabled");
  both_needed_a: assert property (
    (am && !loop_unlock_i)[*7] |=> rx_audio_data_o == $past(rx_audio_data_i))
    else $error("audio muted on single loss");
  mute_release_a: assert property (
    (am && !decoder_unlock_i)[*7]
    |=> rx_audio_data_o == $past(rx_audio_data_i))
    else $error("mute not released");
  clk_stop_a: assert property (
    (!cm && loop_unlock_i)[*7] |-> !rec_clk_o)
    else $error("clock not stopped");
  clk_free_a: assert property (
    cm |=> rec_clk_o == $past(rec_clk_tick_i))
    else $error("clock not free running");
  clk_resume_a: assert property (
    (!loop_unlock_i)[*7] |=> rec_clk_o == $past(rec_clk_tick_i))
    else $error("clock not resumed");
  cfg1_split_a: assert property (
    acc && ix == ref_mult_cfg1_idx[5:0]
    |=> {pre_div_o, int_mult_o[5:2]} == $past(wd))
    else $error("pre-divider field wrong");
  cfg2_split_a: assert property (
    acc && ix == ref_mult_cfg2_idx[5:0]
    |=> {int_mult_o[1:0], frac_mult_o[13:8]} == $past(wd))
    else $error("integer or fraction field wrong");
  frac_low_a: assert property (
    acc && ix == ref_mult_cfg3_idx[5:0] |=> frac_mult_o[7:0] == $past(wd))
    else $error("fraction low byte wrong");
endmodule : rx_clk_checker

bind rx_pll_config_lock_loss rx_clk_checker u_chk (.*);

/* File: ref_stream_model.sv */
`timescale 1ns/1ps
module ref_stream_model (
  // clock
  input  wire logic core_clk_i,
  // commanded lock loss
  input  wire logic dec_lost_i,
  input  wire logic loop_lost_i,
  // toward the block
  output logic      decoder_unlock_o,
  output logic      loop_unlock_o,
  output logic      audio_o,
  output logic      tick_o
);
  logic [3:0] cnt = 4'h0;
  always @(posedge core_clk_i) cnt <= cnt + 4'h1;
  // lock flags straight from the command
  assign decoder_unlock_o = dec_lost_i;
  assign loop_unlock_o    = loop_lost_i;
  // irregular audio bits, clock toggling every other cycle
  assign audio_o = cnt[0] ^ cnt[3];
  assign tick_o  = cnt[1];
endmodule : ref_stream_model

/* File: rx_pll_config_lock_loss_tb.sv */
`timescale 1ns/1ps
module rx_pll_config_lock_loss_tb;
  import rx_clk_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, dl = 1'b0, ll = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [3:0] be = 4'hf, pdiv;
  logic [5:0] jint;
  logic [13:0] dfrac;
  logic wreq, dec_u, loop_u, ain, aout, tick, rclk, a_d, t_d;
  int fail_count = 0, total_checks = 0;

  initial forever #12.5 clk = ~clk;

  ref_stream_model peer (.core_clk_i(clk), .dec_lost_i(dl),
    .loop_lost_i(ll), .decoder_unlock_o(dec_u), .loop_unlock_o(loop_u),
    .audio_o(ain), .tick_o(tick));
  rx_pll_config_lock_loss DUT (.core_clk_i(clk), .rst_i(rst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .decoder_unlock_i(dec_u),
    .loop_unlock_i(loop_u), .rx_audio_data_i(ain), .rx_audio_data_o(aout),
    .rec_clk_tick_i(tick), .rec_clk_o(rclk), .pre_div_o(pdiv),
    .int_mult_o(jint), .frac_mult_o(dfrac));
  always @(posedge clk) begin
    a_d <= ain;
    t_d <= tick;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
           input logic [3:0] b);
    @(posedge clk);
    addr <= a;
    wdat <= {24'h0, d};
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task lock(input logic d, input logic l);
    @(posedge clk);
    dl <= d;
    ll <= l;
    repeat (8) @(posedge clk);
  endtask : lock
  task watch(input logic mute, input logic stop);
    @(posedge clk);
    repeat (8) begin
      @(negedge clk);
      chk(aout, mute ? 1'b0 : a_d);
      chk(rclk, stop ? 1'b0 : t_d);
    end
  endtask : watch
  task regs_test;
    bus(1'b0, 8'h38, 8'h00, 4'hf);
    chk(q, {24'h0, lock_ctrl_rst});
    bus(1'b0, 8'h3c, 8'h00, 4'hf);
    chk(q, {24'h0, ref_mult_cfg1_rst});
    bus(1'b1, 8'h3c, 8'h12, 4'h1);
    bus(1'b1, 8'h40, 8'h1b, 4'h1);
    bus(1'b1, 8'h44, 8'ha3, 4'h1);
    bus(1'b1, 8'h44, 8'hff, 4'he);
    bus(1'b0, 8'h44, 8'h00, 4'hf);
    chk(q, 32'ha3);
    bus(1'b0, 8'h3c, 8'h00, 4'hf);
    chk(q, 32'h12);
    bus(1'b0, 8'h40, 8'h00, 4'hf);
    chk(q, 32'h1b);
    chk({pdiv, jint, dfrac}, {4'h1, 6'h08, 14'h1ba3});
    bus(1'b0, 8'h2c, 8'h00, 4'hf);
    chk(q, 32'h0);
  endtask : regs_test
  task mute_test;
    bus(1'b1, 8'h38, 8'h01, 4'h1);
    lock(1'b1, 1'b1);
    watch(1'b1, 1'b1);
    bus(1'b0, 8'h80, 8'h00, 4'hf);
    chk(q, 32'h1f);
    lock(1'b1, 1'b0);
    watch(1'b0, 1'b0);
    lock(1'b0, 1'b1);
    watch(1'b0, 1'b1);
    bus(1'b0, 8'h80, 8'h00, 4'hf);
    chk(q, 32'h12);
    lock(1'b0, 1'b0);
    watch(1'b0, 1'b0);
    bus(1'b1, 8'h38, 8'h00, 4'h1);
    lock(1'b1, 1'b1);
    watch(1'b0, 1'b1);
  endtask : mute_test
  task clk_test;
    bus(1'b1, 8'h38, 8'h02, 4'h1);
    watch(1'b0, 1'b0);
    bus(1'b1, 8'h38, 8'h03, 4'h1);
    bus(1'b0, 8'h38, 8'h00, 4'hf);
    chk(q, 32'h3);
    watch(1'b1, 1'b0);
    bus(1'b1, 8'h38, 8'h01, 4'h1);
    watch(1'b1, 1'b1);
    lock(1'b0, 1'b0);
    watch(1'b0, 1'b0);
  endtask : clk_test
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    regs_test;
    mute_test;
    clk_test;
    wrap_up;
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
endmodule : rx_pll_config_lock_loss_tb
